// file: shared/bss_pkg.sv
/*
  Shared constants and types of the buck switcher supervisor.
  Assumes a 10 MHz core clock; the timer cycle counts are derived from it.
*/
package bss_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOFT_START_TIME_US = 4000;
  localparam int SHORT_FAULT_TIME_MS = 48;
  localparam int RECOVERY_TIME_MS = 400;
  localparam int STANDBY_DELAY_MS = 20;
  localparam int WAKE_TIME_MAX_NS = 4000;
  localparam int CNT_W = 23;
  localparam logic [CNT_W-1:0] SOFT_START_CYC = CNT_W'((SOFT_START_TIME_US * 1000) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SHORT_FAULT_CYC = CNT_W'((SHORT_FAULT_TIME_MS * 1000000) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RECOVERY_CYC = CNT_W'((RECOVERY_TIME_MS * 1000000) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STANDBY_CYC = CNT_W'((STANDBY_DELAY_MS * 1000000) / CLK_PERIOD_NS);
  // Wake-up is a maximum: round down and leave room for the input synchroniser.
  localparam logic [CNT_W-1:0] WAKE_CYC = CNT_W'((WAKE_TIME_MAX_NS / CLK_PERIOD_NS) - 4);

  // ****************************************
  // Switching cycle defaults
  // ****************************************
  localparam logic [7:0] OSC_PERIOD_CYC = 8'h0A;
  localparam logic [7:0] BLANK_CYC = 8'h03;
  localparam logic [7:0] DEMAG_DELAY_CYC = 8'h02;
  localparam logic [7:0] MAX_ON_CYC = 8'h06;
  localparam int PEAK_W = 4;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ST_RUN_LSB = 0;
  localparam int ST_SW_LSB = 4;
  localparam int ST_STANDBY_BIT = 7;
  localparam int ST_SOURCE_BIT = 8;
  localparam int ST_REDUCED_BIT = 9;
  localparam int ST_AUTH_BIT = 10;
  localparam int ST_SHORT_BIT = 11;
  localparam int ST_OVP_BIT = 12;
  localparam int ST_ALARM_BIT = 13;
  localparam int ST_PIN_BIT = 14;
  localparam int ST_PEAK_LSB = 16;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    BSS_OFF = 3'h1,
    BSS_RUN = 3'h2,
    BSS_RECOVER = 3'h4
  } bss_run_type;

  typedef enum logic [2:0] {
    BSS_SW_WAIT = 3'h1,
    BSS_SW_ON = 3'h2,
    BSS_SW_DEMAG = 3'h4
  } bss_sw_type;

  typedef struct packed {
    logic turn_on;
    logic below_min;
    logic below_short;
    logic drain_ok;
    logic comp_fault;
    logic ovp;
    logic demag;
    logic standby_select_sel;
    logic thermal;
    logic skip;
    logic peak_hit;
    logic [PEAK_W-1:0] comp_level;
  } bss_flags_type;

endpackage

// file: verilog/bss_supervisor.sv
/*
  Supervisory and sequencing logic of an offline buck switcher, with an
  AXI4-Lite register slave.
  Assumes comparator flags arrive as single-bit levels and a 10 MHz clock.
*/
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module bss_supervisor #(
  parameter logic [bss_pkg::CNT_W-1:0] SCP_CYCLES = bss_pkg::SHORT_FAULT_CYC,
  parameter logic [bss_pkg::CNT_W-1:0] RECOVERY_CYCLES = bss_pkg::RECOVERY_CYC,
  parameter logic [bss_pkg::CNT_W-1:0] STANDBY_CYCLES = bss_pkg::STANDBY_CYC,
  parameter logic [bss_pkg::CNT_W-1:0] SOFT_START_CYCLES = bss_pkg::SOFT_START_CYC,
  parameter logic [7:0] OSC_PERIOD = bss_pkg::OSC_PERIOD_CYC
) (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire bss_pkg::bss_flags_type FLAGS,
  input wire logic THERMAL_ALARM_OUT_I,
  output logic THERMAL_ALARM_OUT_O,
  output logic THERMAL_ALARM_OUT_OE,
  output logic GATE_DRIVE_PULSE,
  output logic [bss_pkg::PEAK_W-1:0] PEAK_SETPOINT,
  output logic STARTUP_SOURCE_ON,
  output logic STARTUP_REDUCED,
  output logic STANDBY_MODE,
  output logic CMP_FAST_SEL,
  output logic LV_LOW_POWER,
  input wire logic [bss_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [bss_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  localparam logic [bss_pkg::CNT_W-1:0] SS_STEP = SOFT_START_CYCLES >> bss_pkg::PEAK_W;
  localparam logic [bss_pkg::PEAK_W-1:0] PEAK_MAX = '1;

  typedef struct packed {
    bss_pkg::bss_flags_type sync1;
    bss_pkg::bss_flags_type sync2;
    logic demag_prev;
    bss_pkg::bss_run_type run;
    bss_pkg::bss_sw_type sw;
    logic [bss_pkg::CNT_W-1:0] scp_cnt;
    logic [bss_pkg::CNT_W-1:0] rec_cnt;
    logic [bss_pkg::CNT_W-1:0] ss_cnt;
    logic [bss_pkg::PEAK_W-1:0] ss_level;
    logic [7:0] osc_cnt;
    logic [7:0] sw_cnt;
    logic dem_seen;
    logic [bss_pkg::CNT_W-1:0] standby_select_cnt;
    logic standby_select_arm;
    logic standby;
    logic fast;
    logic low_power;
    logic src_on;
    logic src_out;
    logic reduced;
    logic auth;
    logic gate;
    logic [bss_pkg::PEAK_W-1:0] peak;
    logic alarm_oe;
    logic alarm_o;
    logic short_trip;
    logic ovp_trip;
    logic enable;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bss_state_type;

  bss_state_type st_reg;
  bss_state_type st_next;

  function automatic logic cnt_hit(input logic [bss_pkg::CNT_W-1:0] cnt,
                                   input logic [bss_pkg::CNT_W-1:0] lim);
    cnt_hit = (cnt == lim - 1'b1);
  endfunction

  function automatic logic [31:0] status_word(input bss_state_type s);
    status_word = '0;
    status_word[bss_pkg::ST_RUN_LSB +: 3] = s.run;
    status_word[bss_pkg::ST_SW_LSB +: 3] = s.sw;
    status_word[bss_pkg::ST_STANDBY_BIT] = s.standby;
    status_word[bss_pkg::ST_SOURCE_BIT] = s.src_out;
    status_word[bss_pkg::ST_REDUCED_BIT] = s.reduced;
    status_word[bss_pkg::ST_AUTH_BIT] = s.auth;
    status_word[bss_pkg::ST_SHORT_BIT] = s.short_trip;
    status_word[bss_pkg::ST_OVP_BIT] = s.ovp_trip;
    status_word[bss_pkg::ST_ALARM_BIT] = s.alarm_oe;
    status_word[bss_pkg::ST_PIN_BIT] = THERMAL_ALARM_OUT_I;
    status_word[bss_pkg::ST_PEAK_LSB +: bss_pkg::PEAK_W] = s.peak;
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic allowed;
    logic osc_done;
    logic dem_fall;
    bss_pkg::bss_flags_type f;
    allowed = 1'b0;
    osc_done = 1'b0;
    dem_fall = 1'b0;
    f = st_reg.sync2;
    st_next = st_reg;
    st_next.sync1 = FLAGS;
    st_next.sync2 = st_reg.sync1;
    st_next.demag_prev = f.demag;

    // Start-up source and pulse authorisation.
    if (f.turn_on) begin
      st_next.src_on = 1'b0;
      st_next.auth = 1'b1;
    end
    if (f.below_min) begin
      st_next.src_on = 1'b1;
    end
    st_next.src_out = st_next.src_on && f.drain_ok;
    st_next.reduced = st_next.src_on && f.drain_ok && f.below_short;

    // Run, short-circuit and over-voltage sequencing.
    case (st_reg.run)
      bss_pkg::BSS_OFF: begin
        if (st_reg.auth) begin
          st_next.run = bss_pkg::BSS_RUN;
          st_next.ss_cnt = '0;
          st_next.ss_level = '0;
        end
      end
      bss_pkg::BSS_RUN: begin
        if (f.ovp) begin
          st_next.run = bss_pkg::BSS_RECOVER;
          st_next.ovp_trip = 1'b1;
          st_next.rec_cnt = '0;
        end else if (f.comp_fault) begin
          st_next.scp_cnt = st_reg.scp_cnt + 1'b1;
          if (cnt_hit(st_reg.scp_cnt, SCP_CYCLES)) begin
            st_next.run = bss_pkg::BSS_RECOVER;
            st_next.short_trip = 1'b1;
            st_next.rec_cnt = '0;
          end
        end else begin
          st_next.scp_cnt = '0;
        end
      end
      bss_pkg::BSS_RECOVER: begin
        st_next.rec_cnt = st_reg.rec_cnt + 1'b1;
        if (cnt_hit(st_reg.rec_cnt, RECOVERY_CYCLES)) begin
          if (f.ovp) begin
            st_next.rec_cnt = '0;
          end else begin
            st_next.run = bss_pkg::BSS_RUN;
            st_next.scp_cnt = '0;
            st_next.ss_cnt = '0;
            st_next.ss_level = '0;
            st_next.short_trip = 1'b0;
            st_next.ovp_trip = 1'b0;
          end
        end
      end
      default: begin
        st_next.run = bss_pkg::BSS_OFF;
      end
    endcase

    // Soft-start ramp of the peak setpoint.
    if (st_reg.run == bss_pkg::BSS_RUN && st_next.run == bss_pkg::BSS_RUN
        && st_reg.ss_level != PEAK_MAX) begin
      st_next.ss_cnt = st_reg.ss_cnt + 1'b1;
      if (cnt_hit(st_reg.ss_cnt, SS_STEP)) begin
        st_next.ss_cnt = '0;
        st_next.ss_level = st_reg.ss_level + 1'b1;
      end
    end
    st_next.peak = (f.comp_level < st_next.ss_level) ? f.comp_level : st_next.ss_level;

    // Switching cycle: oscillator, on-time, demagnetisation.
    allowed = st_reg.run == bss_pkg::BSS_RUN && !f.ovp && st_reg.auth && st_reg.enable;
    osc_done = (st_reg.osc_cnt == OSC_PERIOD - 8'h01);
    if (!osc_done) begin
      st_next.osc_cnt = st_reg.osc_cnt + 8'h01;
    end
    dem_fall = st_reg.demag_prev && !f.demag;
    case (st_reg.sw)
      bss_pkg::BSS_SW_WAIT: begin
        if (allowed && osc_done && !f.skip) begin
          st_next.sw = bss_pkg::BSS_SW_ON;
          st_next.gate = 1'b1;
          st_next.osc_cnt = '0;
          st_next.sw_cnt = '0;
        end
      end
      bss_pkg::BSS_SW_ON: begin
        st_next.sw_cnt = st_reg.sw_cnt + 8'h01;
        if (f.peak_hit || st_reg.sw_cnt == bss_pkg::MAX_ON_CYC - 8'h01) begin
          st_next.sw = bss_pkg::BSS_SW_DEMAG;
          st_next.gate = 1'b0;
          st_next.sw_cnt = '0;
          st_next.dem_seen = 1'b0;
        end
      end
      bss_pkg::BSS_SW_DEMAG: begin
        if (st_reg.sw_cnt != 8'hFF) begin
          st_next.sw_cnt = st_reg.sw_cnt + 8'h01;
        end
        if (!st_reg.dem_seen) begin
          if (dem_fall && st_reg.sw_cnt >= bss_pkg::BLANK_CYC) begin
            st_next.dem_seen = 1'b1;
            st_next.sw_cnt = '0;
          end
        end else if (st_reg.sw_cnt == bss_pkg::DEMAG_DELAY_CYC - 8'h01) begin
          st_next.sw = bss_pkg::BSS_SW_WAIT;
        end
      end
      default: begin
        st_next.sw = bss_pkg::BSS_SW_WAIT;
      end
    endcase
    if (!allowed && st_reg.sw == bss_pkg::BSS_SW_ON) begin
      st_next.gate = 1'b0;
      st_next.sw = bss_pkg::BSS_SW_DEMAG;
      st_next.sw_cnt = '0;
      st_next.dem_seen = 1'b0;
    end

    // Standby and active mode timing.
    if (!st_reg.standby) begin
      if (!f.standby_select_sel || st_reg.standby_select_arm) begin
        st_next.standby_select_cnt = st_reg.standby_select_cnt + 1'b1;
        if (cnt_hit(st_reg.standby_select_cnt, STANDBY_CYCLES)) begin
          st_next.standby = 1'b1;
          st_next.standby_select_arm = 1'b0;
          st_next.standby_select_cnt = '0;
        end
      end else begin
        st_next.standby_select_cnt = '0;
      end
    end else if (f.standby_select_sel) begin
      st_next.standby_select_cnt = st_reg.standby_select_cnt + 1'b1;
      if (cnt_hit(st_reg.standby_select_cnt, bss_pkg::WAKE_CYC)) begin
        st_next.standby = 1'b0;
        st_next.standby_select_cnt = '0;
      end
    end else begin
      st_next.standby_select_cnt = '0;
    end
    st_next.fast = !st_next.standby;
    st_next.low_power = st_next.standby;

    st_next.alarm_oe = f.thermal;
    st_next.alarm_o = 1'b0;

    // AXI4-Lite write channel.
    if (st_reg.awready && AWVALID && WVALID) begin
      st_next.awready = 1'b0;
      st_next.wready = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = bss_pkg::RESP_OKAY;
      if (AWADDR == bss_pkg::CTRL_OFFSET) begin
        if (WSTRB[0]) begin
          st_next.enable = WDATA[bss_pkg::CTRL_ENABLE_BIT];
        end
      end else if (AWADDR != bss_pkg::STATUS_OFFSET) begin
        st_next.bresp = bss_pkg::RESP_SLVERR;
      end
    end else if (!st_reg.awready && !st_reg.bvalid && AWVALID && WVALID) begin
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end
    if (st_reg.bvalid && BREADY) begin
      st_next.bvalid = 1'b0;
    end

    // AXI4-Lite read channel.
    if (st_reg.arready && ARVALID) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = bss_pkg::RESP_OKAY;
      st_next.rdata = '0;
      if (ARADDR == bss_pkg::CTRL_OFFSET) begin
        st_next.rdata[bss_pkg::CTRL_ENABLE_BIT] = st_reg.enable;
      end else if (ARADDR == bss_pkg::STATUS_OFFSET) begin
        st_next.rdata = status_word(st_reg);
      end else begin
        st_next.rresp = bss_pkg::RESP_SLVERR;
      end
    end else if (!st_reg.arready && !st_reg.rvalid && ARVALID) begin
      st_next.arready = 1'b1;
    end
    if (st_reg.rvalid && RREADY) begin
      st_next.rvalid = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_reg <= '0;
      st_reg.run <= bss_pkg::BSS_OFF;
      st_reg.sw <= bss_pkg::BSS_SW_WAIT;
      st_reg.src_on <= 1'b1;
      st_reg.standby_select_arm <= 1'b1;
      st_reg.fast <= 1'b1;
      st_reg.enable <= bss_pkg::CTRL_ENABLE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign GATE_DRIVE_PULSE = st_reg.gate;
  assign PEAK_SETPOINT = st_reg.peak;
  assign STARTUP_SOURCE_ON = st_reg.src_out;
  assign STARTUP_REDUCED = st_reg.reduced;
  assign STANDBY_MODE = st_reg.standby;
  assign CMP_FAST_SEL = st_reg.fast;
  assign LV_LOW_POWER = st_reg.low_power;
  assign THERMAL_ALARM_OUT_OE = st_reg.alarm_oe;
  assign THERMAL_ALARM_OUT_O = st_reg.alarm_o;
  assign AWREADY = st_reg.awready;
  assign WREADY = st_reg.wready;
  assign BVALID = st_reg.bvalid;
  assign BRESP = st_reg.bresp;
  assign ARREADY = st_reg.arready;
  assign RVALID = st_reg.rvalid;
  assign RDATA = st_reg.rdata;
  assign RRESP = st_reg.rresp;

  // ****************************************
  // Assertions
  // ****************************************
  localparam int WAKE_BOUND = 40;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_ovp_trip;
    st_reg.run == bss_pkg::BSS_RUN && st_reg.sync2.ovp;
  endsequence

  sequence s_rec_end;
    st_reg.run == bss_pkg::BSS_RECOVER && cnt_hit(st_reg.rec_cnt, RECOVERY_CYCLES);
  endsequence

  ovp_stop_a: assert property (s_ovp_trip |=> !GATE_DRIVE_PULSE
    && st_reg.run == bss_pkg::BSS_RECOVER && st_reg.rec_cnt == '0)
    else $error("over-voltage did not stop switching");
  scp_expire_a: assert property (st_reg.run == bss_pkg::BSS_RUN && !st_reg.sync2.ovp
    && st_reg.sync2.comp_fault && cnt_hit(st_reg.scp_cnt, SCP_CYCLES)
    |=> st_reg.run == bss_pkg::BSS_RECOVER && st_reg.short_trip)
    else $error("short fault timer expiry missed");
  scp_count_a: assert property (st_reg.run == bss_pkg::BSS_RUN && !st_reg.sync2.ovp
    && !st_reg.sync2.comp_fault |=> st_reg.scp_cnt == '0)
    else $error("fault timer not cleared");
  rec_resume_a: assert property (s_rec_end ##0 !st_reg.sync2.ovp
    |=> st_reg.run == bss_pkg::BSS_RUN && st_reg.ss_level == '0)
    else $error("no restart with soft start after recovery");
  rec_again_a: assert property (s_rec_end ##0 st_reg.sync2.ovp
    |=> st_reg.run == bss_pkg::BSS_RECOVER && st_reg.rec_cnt == '0)
    else $error("recovery not repeated");
  rec_quiet_a: assert property (st_reg.run == bss_pkg::BSS_RECOVER
    |=> !$rose(GATE_DRIVE_PULSE))
    else $error("pulse during recovery");
  src_drain_a: assert property (STARTUP_SOURCE_ON |-> $past(st_reg.sync2.drain_ok))
    else $error("start-up source on without drain level");
  reduced_a: assert property (STARTUP_REDUCED |-> STARTUP_SOURCE_ON
    && $past(st_reg.sync2.below_short))
    else $error("reduced current out of condition");
  turn_on_a: assert property (st_reg.sync2.turn_on && !st_reg.sync2.below_min
    |=> !st_reg.src_on && st_reg.auth)
    else $error("turn-on did not stop source");
  below_min_a: assert property (st_reg.sync2.below_min |=> st_reg.src_on)
    else $error("source not restarted below minimum");
  demag_gate_a: assert property ($rose(GATE_DRIVE_PULSE)
    |-> $past(st_reg.sw == bss_pkg::BSS_SW_WAIT && st_reg.osc_cnt == OSC_PERIOD - 8'h01))
    else $error("cycle started before demag end or period end");
  demag_blank_a: assert property (st_reg.sw == bss_pkg::BSS_SW_DEMAG && !st_reg.dem_seen
    && st_reg.sw_cnt < bss_pkg::BLANK_CYC |=> !st_reg.dem_seen)
    else $error("demag end accepted inside blanking");
  skip_a: assert property (st_reg.sync2.skip |=> !$rose(GATE_DRIVE_PULSE))
    else $error("pulse issued in skip");
  standby_in_a: assert property (!st_reg.standby && cnt_hit(st_reg.standby_select_cnt, STANDBY_CYCLES)
    && (!st_reg.sync2.standby_select_sel || st_reg.standby_select_arm) |=> STANDBY_MODE)
    else $error("standby not entered");
  wake_a: assert property (st_reg.standby && st_reg.sync2.standby_select_sel && st_reg.standby_select_cnt == '0
    |-> ##[1:WAKE_BOUND] (!STANDBY_MODE || !st_reg.sync2.standby_select_sel))
    else $error("wake-up too slow");
  alarm_a: assert property (st_reg.sync2.thermal |=> THERMAL_ALARM_OUT_OE
    && !THERMAL_ALARM_OUT_O)
    else $error("alarm not pulled low");
  mode_sel_a: assert property (CMP_FAST_SEL == !STANDBY_MODE && LV_LOW_POWER == STANDBY_MODE)
    else $error("mode select mismatch");
  peak_a: assert property (PEAK_SETPOINT <= $past(st_reg.sync2.comp_level))
    else $error("peak above compensation level");

endmodule

// file: tb/bss_supervisor_tb.sv
/*
  Self-checking testbench of the buck switcher supervisor.
  Assumes shortened timer parameters and a bench-driven demag comparator.
*/
`timescale 1ns/1ns
module bss_supervisor_tb;
  localparam logic [22:0] SCP = 23'h32;
  localparam logic [22:0] REC = 23'h50;
  localparam logic [22:0] SBY = 23'h3C;
  logic clk = 1'b0;
  logic rst = 1'b1;
  bss_pkg::bss_flags_type fl = '0;
  bss_pkg::bss_flags_type flw;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, gp = 1'b0;
  logic awr, wr, bv, arr, rv, gate, oe, ao, so, red, sby, fast, lvp, pin;
  logic [1:0] bresp, rresp, rp;
  logic [31:0] rdata, rd;
  logic [3:0] peak;
  logic [7:0] dmc = 8'h00;
  logic [7:0] dml = 8'h03;
  int failures = 0, checks = 0, pulses = 0, cyc = 0, k;

  initial begin
    forever #50 clk = ~clk;
  end

  // The demag flag stays high while the gate is on and for dml cycles after.
  always_comb begin
    flw = fl;
    flw.demag = (dmc != 8'h00);
  end
  assign pin = oe ? ao : 1'b1;

  bss_supervisor #(.SCP_CYCLES(SCP), .RECOVERY_CYCLES(REC), .STANDBY_CYCLES(SBY),
    .SOFT_START_CYCLES(23'h40), .OSC_PERIOD(8'h14)) i_dut (
    .REF_CLK(clk), .SYS_RST(rst), .FLAGS(flw), .THERMAL_ALARM_OUT_I(pin),
    .THERMAL_ALARM_OUT_O(ao), .THERMAL_ALARM_OUT_OE(oe), .GATE_DRIVE_PULSE(gate),
    .PEAK_SETPOINT(peak), .STARTUP_SOURCE_ON(so), .STARTUP_REDUCED(red),
    .STANDBY_MODE(sby), .CMP_FAST_SEL(fast), .LV_LOW_POWER(lvp),
    .AWADDR(awa), .AWVALID(awv), .AWREADY(awr), .WDATA(wd), .WSTRB(4'hF), .WVALID(wv),
    .WREADY(wr), .BRESP(bresp), .BVALID(bv), .BREADY(br), .ARADDR(ara), .ARVALID(arv),
    .ARREADY(arr), .RDATA(rdata), .RRESP(rresp), .RVALID(rv), .RREADY(rr));

  always @(posedge clk) begin
    cyc++;
    gp <= gate;
    if (gate === 1'b1 && gp !== 1'b1) pulses++;
    dmc <= (gate === 1'b1) ? dml : ((dmc != 8'h00) ? dmc - 8'h01 : 8'h00);
    if (cyc > 4000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cw(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    forever begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) begin
        br <= 1'b0;
        rp = bresp;
        break;
      end
    end
    // One idle edge keeps the next call from driving the same strobe in this step.
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    forever begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        rr <= 1'b0;
        rd = rdata;
        rp = rresp;
        break;
      end
    end
    // One idle edge keeps the next call from driving the same strobe in this step.
    @(posedge clk);
  endtask

  task automatic st(input logic [2:0] e);
    rd_reg(8'h04);
    chk(32'(rd[2:0]), 32'(e));
  endtask

  // ********************
  // Test sequence
  // ********************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 200 && sby !== 1'b1; k++) @(posedge clk);
    chk(32'(k >= SBY && k <= SBY + 5), 32'h1);
    chk(32'({fast, lvp}), 32'h1);
    fl.standby_select_sel <= 1'b1;
    for (k = 0; k < 60 && sby !== 1'b0; k++) @(posedge clk);
    chk(32'(k <= 40), 32'h1);
    chk(32'({fast, lvp}), 32'h2);
    rd_reg(8'h00);
    chk(rd, 32'h1);
    rd_reg(8'h08);
    chk(32'(rp), 32'h2);
    wr_reg(8'h08, 32'h0);
    chk(32'(rp), 32'h2);
    wr_reg(8'h00, 32'h1);
    chk(32'(rp), 32'h0);
    fl.drain_ok <= 1'b1;
    fl.below_short <= 1'b1;
    fl.below_min <= 1'b1;
    cw(5);
    chk(32'({so, red}), 32'h3);
    fl.drain_ok <= 1'b0;
    cw(5);
    chk(32'(so), 32'h0);
    fl.drain_ok <= 1'b1;
    fl.below_short <= 1'b0;
    cw(5);
    chk(32'({so, red}), 32'h2);
    fl.turn_on <= 1'b1;
    fl.below_min <= 1'b0;
    fl.peak_hit <= 1'b1;
    fl.comp_level <= 4'hF;
    cw(5);
    chk(32'(so), 32'h0);
    st(3'h2);
    chk(32'(rd[10]), 32'h1);
    fl.turn_on <= 1'b0;
    fl.below_min <= 1'b1;
    cw(5);
    fl.below_min <= 1'b0;
    cw(5);
    chk(32'(so), 32'h1);
    fl.turn_on <= 1'b1;
    cw(20);
    pulses = 0;
    cw(200);
    chk(32'(pulses >= 9 && pulses <= 11), 32'h1);
    dml <= 8'h28;
    cw(50);
    pulses = 0;
    cw(200);
    chk(32'(pulses >= 3 && pulses <= 5), 32'h1);
    dml <= 8'h03;
    fl.skip <= 1'b1;
    cw(60);
    pulses = 0;
    cw(100);
    chk(32'(pulses), 32'h0);
    fl.skip <= 1'b0;
    fl.comp_level <= 4'h5;
    cw(5);
    chk(32'(peak), 32'h5);
    fl.comp_level <= 4'hF;
    fl.comp_fault <= 1'b1;
    cw(40);
    st(3'h2);
    cw(20);
    st(3'h4);
    chk(32'(rd[11]), 32'h1);
    pulses = 0;
    cw(50);
    chk(32'(pulses), 32'h0);
    fl.comp_fault <= 1'b0;
    for (k = 0; k < 100 && gate !== 1'b1; k++) @(posedge clk);
    chk(32'(peak < 4'hF), 32'h1);
    cw(80);
    chk(32'(peak), 32'hF);
    st(3'h2);
    fl.ovp <= 1'b1;
    cw(4);
    chk(32'(gate), 32'h0);
    st(3'h4);
    chk(32'(rd[12]), 32'h1);
    cw(100);
    st(3'h4);
    fl.ovp <= 1'b0;
    cw(100);
    st(3'h2);
    fl.thermal <= 1'b1;
    cw(4);
    chk(32'({oe, ao}), 32'h2);
    rd_reg(8'h04);
    chk(32'(rd[14:13]), 32'h1);
    fl.thermal <= 1'b0;
    cw(4);
    chk(32'(oe), 32'h0);
    test_done();
  end
endmodule
